// ===== include/mcrt_consts.vh
// constants for the main clock controller with time-base timer
// assumes byte-wide register port, oscillator clock as CLOCK_IN
`ifndef MCRT_CONSTS_VH
`define MCRT_CONSTS_VH
`define MCRT_CSR_ADDR      8'h29
`define MCRT_MISC_ADDR     8'h20
`define MCRT_CSR_RESET     8'h01
`define MCRT_MISC_RESET    8'h00
`define MCRT_TB_LSB        2
`define MCRT_IE_BIT        1
`define MCRT_FLAG_BIT      0
`define MCRT_MCO_BIT       5
`define MCRT_CP_LSB        1
`define MCRT_SMS_BIT       0
`define MCRT_PERIOD_0      19'd32000
`define MCRT_PERIOD_1      19'd64000
`define MCRT_PERIOD_2      19'd160000
`define MCRT_PERIOD_3      19'd400000
`endif

// ===== hdl/mcrt_divider.v
// free-running power-of-two divider giving half-rate enables
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module mcrt_divider #(
  parameter WIDTH = 5
) (
  input  wire             clk_in,   // oscillator clock
  input  wire             nrst_in,  // async reset, active low
  output wire [WIDTH-1:0] count_out // divider state
);
  reg [WIDTH-1:0] count_reg;
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      count_reg <= {WIDTH{1'b0}};
    else
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  end
  assign count_out = count_reg;
endmodule // mcrt_divider
`default_nettype wire

// ===== hdl/mcrt_top.v
// main clock controller: cpu prescaler, clock-out, time-base timer
// assumes byte register port with read data one cycle after the strobe
// Overview of operation
// - cpu clock comes from oscillator via prescaler set by divider and slow bits
// - normal gives /2; slow codes 00,10,01,11 give /4,/8,/16,/32
// - can clock always runs at oscillator/2
// - clock-out enable drives oscillator/2 onto pin alternate function
// - clock-out enable is read/write, zero after reset
// - clock-out stops during tick halt mode
// - time-base select picks 32000, 64000, 160000 or 400000 cycles
// - new time-base select applies only at end of running period
// - period end sets tick flag; reading status register clears it only in run mode, not in either halt mode
// - interrupt request when tick flag and tick interrupt enable both set
// - halt with tick interrupt enabled enters tick halt mode
// - status register bits 7 to 4 read zero
// - status register resets to 01h
// - in wait mode timer runs and its interrupt ends wait
// - in tick halt counter runs, registers frozen, interrupt wakes
// - in full halt counter and registers freeze; tick cannot wake
// - prescaler, clock-out and timer work independently and together
`timescale 1ns/1ps
`default_nettype none
`include "mcrt_consts.vh"
module mcrt_top (
  input  wire       CLOCK_IN,        // oscillator clock
  input  wire       NRST_IN,         // async reset, active low
  input  wire [7:0] ADDR_IN,         // register address
  input  wire [7:0] WDATA_IN,        // write data
  input  wire       WR_IN,           // write strobe
  input  wire       RD_IN,           // read strobe
  output reg  [7:0] RDATA_OUT,       // read data, cycle after strobe
  input  wire       HALT_EXEC_IN,    // halt instruction executed pulse
  input  wire       WAIT_IN,         // cpu in wait mode level
  input  wire       HALT_WAKE_IN,    // another interrupt able to end halt
  output wire       CPU_CLK_EN_OUT,  // cpu clock enable pulse
  output wire       CAN_CLK_EN_OUT,  // can clock enable pulse, osc/2
  output reg        CLK_OUT_OUT,     // clock-out pin level
  output wire       CLK_OUT_OE_OUT,  // clock-out alternate function select
  output wire       TICK_IRQ_OUT,    // tick interrupt request
  output wire       TICK_HALT_OUT,   // low-power tick halt mode level
  output wire       FULL_HALT_OUT,   // full halt mode level
  output wire       WAKE_OUT         // wake pulse from wait or tick halt
);
  localparam MODE_RUN  = 2'd0;
  localparam MODE_TICK = 2'd1;
  localparam MODE_HALT = 2'd2;

  reg  [1:0]  mode_reg;
  reg  [1:0]  mode_next;
  reg  [1:0]  time_base_select_reg;
  reg  [1:0]  active_tb_reg;
  reg         tick_irq_enable_reg;
  reg         tick_flag_reg;
  reg         clock_out_enable_reg;
  reg  [1:0]  slow_divider_select_reg;
  reg         slow_mode_select_reg;
  reg  [18:0] tb_count_reg;
  reg  [18:0] period;
  reg         cpu_en;
  wire [4:0]  div_count;
  wire        frozen;
  wire        regs_frozen;
  wire        period_end;
  wire        csr_rd;
  wire        csr_wr;
  wire        misc_wr;

  mcrt_divider #(.WIDTH(5)) u_div (
    .clk_in    (CLOCK_IN),
    .nrst_in   (NRST_IN),
    .count_out (div_count)
  );

  // prescaler: enable pulse once per division period
  always @*
  begin
    if (!slow_mode_select_reg)
      cpu_en = div_count[0];
    else
    begin
      case (slow_divider_select_reg)
        2'b00:   cpu_en = &div_count[1:0];
        2'b10:   cpu_en = &div_count[2:0];
        2'b01:   cpu_en = &div_count[3:0];
        2'b11:   cpu_en = &div_count[4:0];
        default: cpu_en = div_count[0];
      endcase
    end
  end
  assign CPU_CLK_EN_OUT = cpu_en;
  assign CAN_CLK_EN_OUT = div_count[0];

  assign CLK_OUT_OE_OUT = clock_out_enable_reg;
  always @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      CLK_OUT_OUT <= 1'b0;
    else if (clock_out_enable_reg && mode_reg != MODE_TICK)
      CLK_OUT_OUT <= ~CLK_OUT_OUT;
    else
      CLK_OUT_OUT <= 1'b0;
  end

  // power modes
  always @*
  begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_RUN:
      begin
        if (HALT_EXEC_IN)
          mode_next = tick_irq_enable_reg ? MODE_TICK : MODE_HALT;
      end
      MODE_TICK:
      begin
        if (TICK_IRQ_OUT || HALT_WAKE_IN)
          mode_next = MODE_RUN;
      end
      MODE_HALT:
      begin
        if (HALT_WAKE_IN)
          mode_next = MODE_RUN;
      end
      default: mode_next = MODE_RUN;
    endcase
  end
  always @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      mode_reg <= MODE_RUN;
    else
      mode_reg <= mode_next;
  end
  assign TICK_HALT_OUT = (mode_reg == MODE_TICK);
  assign FULL_HALT_OUT = (mode_reg == MODE_HALT);
  assign WAKE_OUT = TICK_IRQ_OUT && (WAIT_IN || mode_reg == MODE_TICK);

  assign frozen      = (mode_reg == MODE_HALT);
  assign regs_frozen = (mode_reg != MODE_RUN);

  // time-base period
  always @*
  begin
    case (active_tb_reg)
      2'b00:   period = `MCRT_PERIOD_0;
      2'b01:   period = `MCRT_PERIOD_1;
      2'b10:   period = `MCRT_PERIOD_2;
      2'b11:   period = `MCRT_PERIOD_3;
      default: period = `MCRT_PERIOD_0;
    endcase
  end
  assign period_end = !frozen && (tb_count_reg == period - 19'd1);

  always @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      tb_count_reg  <= 19'd0;
      active_tb_reg <= 2'b00;
    end
    else if (period_end)
    begin
      tb_count_reg  <= 19'd0;
      active_tb_reg <= time_base_select_reg;
    end
    else if (!frozen)
      tb_count_reg <= tb_count_reg + 19'd1;
  end

  // register port
  assign csr_rd  = RD_IN && ADDR_IN == `MCRT_CSR_ADDR && !regs_frozen;
  assign csr_wr  = WR_IN && ADDR_IN == `MCRT_CSR_ADDR && !regs_frozen;
  assign misc_wr = WR_IN && ADDR_IN == `MCRT_MISC_ADDR && !regs_frozen;

  always @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      time_base_select_reg <= 2'b00;
      tick_irq_enable_reg  <= 1'b0;
    end
    else if (csr_wr)
    begin
      time_base_select_reg <= WDATA_IN[`MCRT_TB_LSB+1:`MCRT_TB_LSB];
      tick_irq_enable_reg  <= WDATA_IN[`MCRT_IE_BIT];
    end
  end

  always @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      tick_flag_reg <= 1'b1;
    else if (period_end)
      tick_flag_reg <= 1'b1;
    else if (csr_rd)
      tick_flag_reg <= 1'b0;
  end
  assign TICK_IRQ_OUT = tick_flag_reg && tick_irq_enable_reg;

  always @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      clock_out_enable_reg    <= 1'b0;
      slow_divider_select_reg <= 2'b00;
      slow_mode_select_reg    <= 1'b0;
    end
    else if (misc_wr)
    begin
      clock_out_enable_reg    <= WDATA_IN[`MCRT_MCO_BIT];
      slow_divider_select_reg <= WDATA_IN[`MCRT_CP_LSB+1:`MCRT_CP_LSB];
      slow_mode_select_reg    <= WDATA_IN[`MCRT_SMS_BIT];
    end
  end

  always @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN && ADDR_IN == `MCRT_CSR_ADDR)
      RDATA_OUT <= {4'h0, time_base_select_reg, tick_irq_enable_reg,
                    tick_flag_reg};
    else if (RD_IN && ADDR_IN == `MCRT_MISC_ADDR)
      RDATA_OUT <= {2'b00, clock_out_enable_reg, 2'b00,
                    slow_divider_select_reg, slow_mode_select_reg};
    else
      RDATA_OUT <= 8'h00;
  end
endmodule // mcrt_top
`default_nettype wire

// ===== verification/mcrt_asserts.sv
// port assertions for the clock controller
// assumes bind to mcrt_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module mcrt_chk (
  input wire logic       CLOCK_IN,       // clock
  input wire logic       NRST_IN,        // reset
  input wire logic [7:0] ADDR_IN,        // addr
  input wire logic       RD_IN,          // read
  input wire logic [7:0] RDATA_OUT,      // data
  input wire logic       HALT_EXEC_IN,   // halt
  input wire logic       HALT_WAKE_IN,   // wake
  input wire logic       CAN_CLK_EN_OUT, // can
  input wire logic       CLK_OUT_OUT,    // pin
  input wire logic       CLK_OUT_OE_OUT, // oe
  input wire logic       TICK_IRQ_OUT,   // irq
  input wire logic       TICK_HALT_OUT,  // tick halt
  input wire logic       FULL_HALT_OUT   // full halt
);
  wire run = !TICK_HALT_OUT && !FULL_HALT_OUT;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence csr_rd; RD_IN && ADDR_IN == 8'h29; endsequence
  sequence csr_clr; RD_IN && ADDR_IN == 8'h29 && run; endsequence
  can_rate_a: assert property ($past(NRST_IN) |-> CAN_CLK_EN_OUT != $past(CAN_CLK_EN_OUT))
    else $error("can rate");
  cko_tgl_a: assert property ((CLK_OUT_OE_OUT && !TICK_HALT_OUT)[*2] |-> CLK_OUT_OUT != $past(CLK_OUT_OUT))
    else $error("clock out toggle");
  cko_halt_a: assert property (TICK_HALT_OUT[*2] |-> !CLK_OUT_OUT)
    else $error("clock out in halt");
  rsv_zero_a: assert property (csr_rd |=> RDATA_OUT[7:4] == 4'h0)
    else $error("reserved bits");
  irq_flag_a: assert property (csr_rd |=> (RDATA_OUT[1] & RDATA_OUT[0]) == $past(TICK_IRQ_OUT))
    else $error("irq mismatch");
  flag_clr_a: assert property (csr_clr ##1 csr_rd |=> !RDATA_OUT[0])
    else $error("flag not cleared");
  halt_split_a: assert property (HALT_EXEC_IN && run |=> TICK_HALT_OUT != FULL_HALT_OUT)
    else $error("halt entry");
  full_hold_a: assert property (FULL_HALT_OUT && !HALT_WAKE_IN |=> FULL_HALT_OUT)
    else $error("full halt left");
endmodule // mcrt_chk
bind mcrt_top mcrt_chk mcrt_chk_inst (.*);
`default_nettype wire

// ===== verification/mcrt_cpu_model.sv
// cpu model: sleeps in wait mode until woken
// assumes the wake level of the clock controller
`timescale 1ns/1ps
`default_nettype none
module mcrt_cpu_model (
  input  wire logic clk_in,   // clock
  input  wire logic nrst_in,  // reset
  input  wire logic sleep_in, // enter wait
  input  wire logic wake_in,  // wake
  output var  logic wait_out  // in wait
);
  always @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
      wait_out <= 1'b0;
    else if (wake_in)
      wait_out <= 1'b0;
    else if (sleep_in)
      wait_out <= 1'b1;
endmodule // mcrt_cpu_model
`default_nettype wire

// ===== verification/tb.sv
// bench: registers, prescaler, halt modes, timer
// assumes free clock and the cpu model on wait
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, nrst = 0, wr = 0, rd = 0, hx = 0, hw = 0, slp = 0;
  logic [7:0]  adr = 0, wd = 0, m_misc;
  logic [31:0] rs = 32'h4005;
  wire  [7:0]  rdat;
  wire         can, cko, oe, irq, th, fh, wk, wt, cpu;
  int          mismatches = 0, check_count = 0, cyc = 0, n, t = 0;
  int          per_q[$] = '{32000, 64000};
  logic [7:0]  cfg[5] = '{8'h20, 8'h21, 8'h25, 8'h23, 8'h27};
  mcrt_top mcrt_top_inst (.CLOCK_IN(clk), .NRST_IN(nrst), .ADDR_IN(adr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .HALT_EXEC_IN(hx), .WAIT_IN(wt),
    .HALT_WAKE_IN(hw), .CPU_CLK_EN_OUT(cpu), .CAN_CLK_EN_OUT(can), .CLK_OUT_OUT(cko),
    .CLK_OUT_OE_OUT(oe), .TICK_IRQ_OUT(irq), .TICK_HALT_OUT(th), .FULL_HALT_OUT(fh),
    .WAKE_OUT(wk));
  mcrt_cpu_model mcrt_cpu_model_inst (.clk_in(clk), .nrst_in(nrst), .sleep_in(slp),
    .wake_in(wk), .wait_out(wt));
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= nrst ? cyc + 1 : 0;
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // whole-byte writes only, never read-modify-write
  task wreg(input logic [7:0] a, d);
    @(posedge clk) adr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk) wr <= 0;
  endtask
  task rreg(input logic [7:0] a, e);
    @(posedge clk) adr <= a;
    rd <= 1;
    @(posedge clk) rd <= 0;
    #1 chk("rdata", e, rdat);
  endtask
  // two status reads back to back, strobe held across both
  task rreg2(input logic [7:0] e1, e2);
    @(posedge clk) adr <= 8'h29;
    rd <= 1;
    @(posedge clk) #1 chk("rdata", e1, rdat);
    @(posedge clk) rd <= 0;
    #1 chk("rdata", e2, rdat);
  endtask
  task per(input int e);
    n = 0;
    @(posedge clk iff cpu === 1);
    do @(posedge clk) n++; while (cpu !== 1 && n < 64);
    chk("cpu period", e, n);
  endtask
  task pulse_halt;
    @(posedge clk) hx <= 1;
    @(posedge clk) hx <= 0;
    repeat (2) @(posedge clk);
  endtask
  task tick;
    t += per_q.pop_front();
    do @(posedge clk) #1; while (irq !== 1 && cyc < 99000);
    chk("tick time", t, cyc);
  endtask
  initial
  begin
    #5200000 mismatches++;
    end_sim;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    rreg2(8'h01, 8'h00);
    rreg(8'h20, 8'h00);
    rs = xs(rs);
    rreg(rs[7:0] | 8'h80, 8'h00);
    rs = xs(rs);
    m_misc = rs[7:0] & 8'h27;
    wreg(8'h20, rs[7:0]);
    rreg(8'h20, m_misc);
    for (int i = 0; i < 5; i++)
    begin
      wreg(8'h20, cfg[i]);
      per(2 << i);
    end
    wreg(8'h29, 8'h00);
    pulse_halt;
    chk("full halt", 1, fh);
    wreg(8'h20, 8'h00);
    @(posedge clk) hw <= 1;
    @(posedge clk) hw <= 0;
    repeat (2) @(posedge clk);
    chk("full halt", 0, fh);
    rreg(8'h20, 8'h27);
    @(posedge clk) nrst <= 0;
    repeat (5) @(posedge clk);
    nrst <= 1;
    rreg(8'h29, 8'h01);
    wreg(8'h29, 8'h06);
    @(posedge clk) slp <= 1;
    @(posedge clk) slp <= 0;
    #1 chk("wait", 1, wt);
    tick;
    repeat (2) @(posedge clk);
    chk("wait", 0, wt);
    rreg(8'h29, 8'h07);
    pulse_halt;
    chk("tick halt", 1, th);
    wreg(8'h29, 8'h00);
    tick;
    repeat (2) @(posedge clk);
    chk("tick halt", 0, th);
    rreg(8'h29, 8'h07);
    end_sim;
  end
endmodule // tb
`default_nettype wire
